// ### verilog/twsio_pkg.sv
// Constants, types and helpers shared by the three-wire serial channel.
// Assumes a byte-wide register port with a 16-bit address.
package twsio_pkg;

	typedef logic [15:0] twsio_addr_t;
	typedef logic [7:0]  twsio_byte_t;

	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam twsio_addr_t ADR_MODE  = 16'hFF68;
	localparam twsio_addr_t ADR_AUTO  = 16'hFF69;
	localparam twsio_addr_t ADR_PRESC = 16'hFF43;
	localparam twsio_addr_t ADR_SHIFT = 16'hFF6F;
	localparam twsio_addr_t ADR_PDIR  = 16'hFF70;
	localparam twsio_addr_t ADR_PLAT  = 16'hFF71;
	localparam twsio_addr_t ADR_PIN   = 16'hFF72;
	localparam twsio_addr_t ADR_STAT  = 16'hFF73;

	// ---------------------------------------------------------------
	// Reset values and writable masks
	// ---------------------------------------------------------------
	localparam twsio_byte_t RST_MODE   = 8'h00;
	localparam twsio_byte_t RST_AUTO   = 8'h00;
	localparam twsio_byte_t RST_PRESC  = 8'h88;
	localparam twsio_byte_t RST_PDIR   = 8'hFF;
	localparam twsio_byte_t RST_PLAT   = 8'h00;
	localparam twsio_byte_t MODE_WMASK = 8'hE3;
	localparam twsio_byte_t AUTO_WMASK = 8'hE7;
	localparam twsio_byte_t BYTE_ZERO  = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned MODE_EN_BIT    = 7;
	localparam int unsigned MODE_DIR_BIT   = 6;
	localparam int unsigned MODE_AUTOSEL_BIT = 5;
	localparam int unsigned MODE_SELHI_BIT = 1;
	localparam int unsigned MODE_SELLO_BIT = 0;
	localparam int unsigned AUTO_RX_BIT    = 7;
	localparam int unsigned PRESC_RATE_LSB = 4;
	localparam int unsigned PIN_SI         = 0;
	localparam int unsigned PIN_SO         = 1;
	localparam int unsigned PIN_SCK        = 2;
	localparam int unsigned STAT_DONE_BIT  = 0;
	localparam int unsigned STAT_BUSY_BIT  = 1;

	// ---------------------------------------------------------------
	// Widths and counts
	// ---------------------------------------------------------------
	localparam int unsigned RATE_W      = 4;
	localparam int unsigned CNT_W       = 4;
	localparam int unsigned PRESC_CNT_W = 16;
	localparam int unsigned NPIN        = 3;
	localparam logic [3:0]  XFER_LAST   = 4'h7;
	localparam logic [3:0]  CNT_ONE     = 4'h1;
	localparam logic [3:0]  CNT_ZERO    = 4'h0;

	typedef enum logic {TWSIO_IDLE, TWSIO_SHIFT} twsio_state_e;

	// Bit reversal between internal bus and shift register
	function automatic twsio_byte_t twsio_order(input twsio_byte_t v, input logic rev);
		twsio_byte_t r;
		r = v;
		if (rev)
		begin
			for (int i = 0; i < 8; i++)
			begin
				r[i] = v[7 - i];
			end
		end
		return r;
	endfunction

endpackage

// ### verilog/twsio_tick_if.sv
// Carrier between the serial core and its internal clock divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface twsio_tick_if;
	logic [3:0] rate;
	logic       run;
	logic       tick;

	modport gen  (input rate, input run, output tick);
	modport user (output rate, output run, input tick);
endinterface

// ### verilog/twsio_presc.sv
// Divider that makes the half-period enable pulse of the internal clock.
// Assumes rate and run come from logic on the same clock.
`timescale 1ns/100ps
module twsio_presc
	import twsio_pkg::*;
(
	// Clock and reset
	input  wire logic   sys_clk_i,
	input  wire logic   rst_n_i,
	// Divider control and tick
	twsio_tick_if.gen   tk
);

	logic [PRESC_CNT_W-1:0] cnt_q;
	logic [PRESC_CNT_W-1:0] cnt_d;
	logic [PRESC_CNT_W-1:0] limit;
	logic                   tick_d;
	logic                   tick_q;

	// ---------------------------------------------------------------
	// Half period is 2^(rate+1) system cycles
	// ---------------------------------------------------------------
	always_comb
	begin
		limit  = PRESC_CNT_W'((32'd1 << (32'(tk.rate) + 32'd1)) - 32'd1);
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!tk.run)
		begin
			cnt_d = '0;
		end
		else if (cnt_q >= limit)
		begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
		else
		begin
			cnt_d = cnt_q + PRESC_CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tk.tick = tick_q & tk.run;

endmodule

// ### verilog/twsio_top.sv
// Three-wire serial channel: mode, shift and port registers plus shifter.
// Assumes a byte register port and one system clock; pins are split in/out/oe.
//
// Overview of operation
// - Reset clears mode register to zero
// - Disabled: shifter halted, counter cleared, pins are ports
// - Clock source: external, timer 2, or prescaler
// - Mode select bit chooses plain or automatic
// - Order bit picks MSB-first or LSB-first
// - Order reversed at bus, shift direction fixed
// - Eight bits, one per clock, full duplex
// - Shift on falling edge, output from latch
// - Sample input on rising clock edge
// - After eighth bit stop and flag completion
// - Shift register write drives output low
// - Write starts transfer only when enabled
// - Start only after end, clock idle high
// - Clock pin direction follows selected clock source
// - Transmit only leaves input pin as port
// - Shift register contents undefined after reset
// - Enabling after a write does not start
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module twsio_top
	import twsio_pkg::*;
(
	// Clock and reset
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	// Register port
	input  wire twsio_pkg::twsio_addr_t reg_addr_i,
	input  wire twsio_pkg::twsio_byte_t reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic [7:0]              reg_rdata_o,
	// Clock sources
	input  wire logic               timer2_output_i,
	// Serial pins
	input  wire logic               serial_in_pin_i,
	output logic                    serial_in_pin_o,
	output logic                    serial_in_pin_oe_o,
	input  wire logic               serial_out_pin_i,
	output logic                    serial_out_pin_o,
	output logic                    serial_out_pin_oe_o,
	input  wire logic               serial_clock_pin_i,
	output logic                    serial_clock_pin_o,
	output logic                    serial_clock_pin_oe_o,
	// Status
	output logic                    transfer_done_irq_flag_o,
	output logic                    auto_transfer_select_o,
	output logic                    busy_o
);

	twsio_tick_if tk ();

	twsio_presc u_presc (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.tk        (tk)
	);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	twsio_byte_t       mode_q, mode_d, auto_q, auto_d, presc_q, presc_d;
	twsio_byte_t       pdir_q, pdir_d, plat_q, plat_d, rdata_q, rdata_d;
	twsio_byte_t       sr_q, sr_d;
	twsio_state_e      st_q, st_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              sclk_q, sclk_d, so_q, so_d, done_q, done_d;
	logic [NPIN-1:0]   s1_q, s2_q, s3_q, lvl_q, lvl_d;

	logic channel_enable, serial_dir, clock_src_sel_hi, clock_src_sel_lo, rx_allow;
	logic wr_mode, wr_shift, start, src_tick, fall, rise, done_set, done_clr;

	assign channel_enable   = mode_q[MODE_EN_BIT];
	assign serial_dir       = mode_q[MODE_DIR_BIT];
	assign clock_src_sel_hi = mode_q[MODE_SELHI_BIT];
	assign clock_src_sel_lo = mode_q[MODE_SELLO_BIT];
	assign rx_allow         = auto_q[AUTO_RX_BIT];
	assign wr_mode          = reg_wr_i && (reg_addr_i == ADR_MODE);
	assign wr_shift         = reg_wr_i && (reg_addr_i == ADR_SHIFT);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NPIN; i++)
		begin
			lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			lvl_q <= '1;
		end
		else
		begin
			s1_q  <= {serial_clock_pin_i, serial_out_pin_i, serial_in_pin_i};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// ---------------------------------------------------------------
	// Clock source and edges
	// ---------------------------------------------------------------
	// source selection
	assign tk.run   = (st_q == TWSIO_SHIFT) && clock_src_sel_hi && clock_src_sel_lo;
	assign tk.rate  = presc_q[PRESC_RATE_LSB +: RATE_W];
	assign src_tick = clock_src_sel_lo ? tk.tick : timer2_output_i;

	always_comb
	begin
		fall = 1'b0;
		rise = 1'b0;
		if (st_q == TWSIO_SHIFT)
		begin
			if (clock_src_sel_hi)
			begin
				fall = src_tick && sclk_q;
				rise = src_tick && !sclk_q;
			end
			else
			begin
				fall = lvl_q[PIN_SCK] && !lvl_d[PIN_SCK];
				rise = !lvl_q[PIN_SCK] && lvl_d[PIN_SCK];
			end
		end
	end

	assign start = wr_shift && channel_enable && (st_q == TWSIO_IDLE)
		&& (clock_src_sel_hi || lvl_q[PIN_SCK]);

	// ---------------------------------------------------------------
	// Shifter
	// ---------------------------------------------------------------
	always_comb
	begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		sclk_d   = sclk_q;
		so_d     = so_q;
		sr_d     = sr_q;
		done_set = 1'b0;
		unique case (st_q)
			TWSIO_IDLE:
			begin
				sclk_d = 1'b1;
				cnt_d  = CNT_ZERO;
				if (wr_shift)
				begin
					sr_d = twsio_order(reg_wdata_i, serial_dir);
					so_d = 1'b0;
				end
				if (start)
				begin
					st_d = TWSIO_SHIFT;
				end
			end
			TWSIO_SHIFT:
			begin
				if (fall)
				begin
					sclk_d = 1'b0;
					so_d   = sr_q[7];
					sr_d   = {sr_q[6:0], sr_q[0]};
				end
				if (rise)
				begin
					sclk_d = 1'b1;
					sr_d   = {sr_q[7:1], lvl_q[PIN_SI]};
					cnt_d  = cnt_q + CNT_ONE;
					if (cnt_q == XFER_LAST)
					begin
						st_d     = TWSIO_IDLE;
						done_set = 1'b1;
						cnt_d    = CNT_ZERO;
					end
				end
			end
		endcase
		if (!channel_enable)
		begin
			st_d   = TWSIO_IDLE;
			cnt_d  = CNT_ZERO;
			sclk_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q   <= TWSIO_IDLE;
			cnt_q  <= CNT_ZERO;
			sclk_q <= 1'b1;
			so_q   <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sclk_q <= sclk_d;
			so_q   <= so_d;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		sr_q <= sr_d;
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	assign done_clr = reg_wr_i && (reg_addr_i == ADR_STAT) && reg_wdata_i[STAT_DONE_BIT];

	always_comb
	begin
		mode_d  = mode_q;
		auto_d  = auto_q;
		presc_d = presc_q;
		pdir_d  = pdir_q;
		plat_d  = plat_q;
		rdata_d = BYTE_ZERO;
		// Set wins over software clear
		done_d  = done_set || (done_q && !done_clr);
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				ADR_MODE:  mode_d  = reg_wdata_i & MODE_WMASK;
				ADR_AUTO:  auto_d  = (reg_wdata_i & AUTO_WMASK) | (auto_q & ~AUTO_WMASK);
				ADR_PRESC: presc_d = reg_wdata_i;
				ADR_PDIR:  pdir_d  = reg_wdata_i;
				ADR_PLAT:  plat_d  = reg_wdata_i;
				default:   mode_d  = mode_q;
			endcase
		end
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				ADR_MODE:  rdata_d = mode_q;
				ADR_AUTO:  rdata_d = auto_q;
				ADR_PRESC: rdata_d = presc_q;
				ADR_SHIFT: rdata_d = twsio_order(sr_q, serial_dir);
				ADR_PDIR:  rdata_d = pdir_q;
				ADR_PLAT:  rdata_d = plat_q;
				ADR_PIN:   rdata_d = {5'h00, lvl_q};
				ADR_STAT:  rdata_d = {6'h00, st_q == TWSIO_SHIFT, done_q};
				default:   rdata_d = BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode_q  <= RST_MODE;
			auto_q  <= RST_AUTO;
			presc_q <= RST_PRESC;
			pdir_q  <= RST_PDIR;
			plat_q  <= RST_PLAT;
			rdata_q <= BYTE_ZERO;
			done_q  <= 1'b0;
		end
		else
		begin
			mode_q  <= mode_d;
			auto_q  <= auto_d;
			presc_q <= presc_d;
			pdir_q  <= pdir_d;
			plat_q  <= plat_d;
			rdata_q <= rdata_d;
			done_q  <= done_d;
		end
	end

	// ---------------------------------------------------------------
	// Pins and outputs
	// ---------------------------------------------------------------
	// pin functions
	assign serial_out_pin_o      = channel_enable ? so_q : plat_q[PIN_SO];
	assign serial_out_pin_oe_o   = channel_enable || !pdir_q[PIN_SO];
	assign serial_clock_pin_o    = channel_enable ? sclk_q : plat_q[PIN_SCK];
	assign serial_clock_pin_oe_o = channel_enable ? clock_src_sel_hi : !pdir_q[PIN_SCK];
	assign serial_in_pin_o       = plat_q[PIN_SI];
	assign serial_in_pin_oe_o    = !(channel_enable && rx_allow) && !pdir_q[PIN_SI];

	assign reg_rdata_o              = rdata_q;
	assign transfer_done_irq_flag_o = done_q;
	assign auto_transfer_select_o   = mode_q[MODE_AUTOSEL_BIT];
	assign busy_o                   = (st_q == TWSIO_SHIFT);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_DISABLED_HALT: assert property (!channel_enable |=> st_q == TWSIO_IDLE && cnt_q == CNT_ZERO)
		else $error("channel disabled but shifter active");
	AST_WRITE_SO_LOW: assert property (wr_shift && st_q == TWSIO_IDLE |=> !so_q)
		else $error("serial output not low after load");
	AST_NO_START_OFF: assert property (wr_shift && !channel_enable |=> st_q == TWSIO_IDLE)
		else $error("transfer started while disabled");
	AST_START_ON: assert property (start |=> st_q == TWSIO_SHIFT && cnt_q == CNT_ZERO)
		else $error("enabled write did not start transfer");
	AST_DONE_EIGHTH: assert property (rise && cnt_q == XFER_LAST |=> done_q && st_q == TWSIO_IDLE)
		else $error("no stop after eighth bit");
	AST_SO_ON_FALL: assert property (fall && channel_enable
		|=> so_q == $past(sr_q[7]) && !sclk_q)
		else $error("output bit not taken on falling edge");
	AST_SAMPLE_RISE: assert property (rise |=> sr_q[0] == $past(lvl_q[PIN_SI]))
		else $error("input not sampled on rising edge");
	AST_ORDER_LOAD: assert property (wr_shift && st_q == TWSIO_IDLE && serial_dir
		|=> sr_q == twsio_order($past(reg_wdata_i), 1'b1))
		else $error("least significant first load not reversed");
	AST_IDLE_HIGH: assert property (st_q == TWSIO_IDLE && clock_src_sel_hi && channel_enable |-> sclk_q && serial_clock_pin_oe_o)
		else $error("internal clock not idle high");
	AST_DONE_SET_WINS: assert property (done_set && done_clr |=> done_q)
		else $error("completion lost to clear");

endmodule

// ### testbench/twsio_peer.sv
// Behavioural far-side peripheral with a synchronous serial port.
// Assumes the bench resolves the clock wire and loads a byte per frame.
`timescale 1ns/100ps
module twsio_peer (
	// Link lines
	input  wire logic sck_i,
	input  wire logic sdi_i,
	output logic      sdo_o,
	output logic      sck_o,
	output logic      sck_oe_o
);
	logic [7:0] tx_q = 8'h00;
	logic [7:0] rx_q = 8'h00;
	int         n = 0;

	initial
	begin
		sdo_o = 1'b0;
		sck_o = 1'b1;
		sck_oe_o = 1'b0;
	end

	task automatic load(input logic [7:0] v);
		tx_q = v;
		n = 0;
		sdo_o = ~v[7];
	endtask

	task automatic run_clock(input realtime half);
		sck_oe_o = 1'b1;
		repeat (8)
		begin
			#half sck_o = 1'b0;
			#half sck_o = 1'b1;
		end
		sck_oe_o = 1'b0;
	endtask

	always @(negedge sck_i)
	begin
		sdo_o <= tx_q[7];
		tx_q <= {tx_q[6:0], 1'b0};
	end

	// sample on rise, invert after frame
	always @(posedge sck_i)
	begin
		rx_q <= {rx_q[6:0], sdi_i};
		if (n == 7)
			sdo_o <= ~sdo_o;
		n <= n + 1;
	end
endmodule

// ### testbench/test_twsio_top.sv
// Self-checking bench: register tasks, read monitor queue, serial peer.
// Assumes the package, design files and peer model are compiled first.
`timescale 1ns/100ps
module test_twsio_top;
	import twsio_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	twsio_addr_t addr = 16'h0000;
	twsio_byte_t wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic        tmr2 = 1'b0;
	logic [2:0]  tdiv = 3'h0;
	logic [7:0]  rdata;
	logic        si_o, si_oe, so_o, so_oe, sck_o, sck_oe, done, ats, busy;
	logic        p_sdo, p_sck, p_sck_oe;
	wire         si_w = si_oe ? si_o : p_sdo;
	wire         so_w = so_oe ? so_o : 1'b1;
	wire         sck_w = sck_oe ? sck_o : (p_sck_oe ? p_sck : 1'b1);
	logic [7:0]  exp_q[$];
	logic [7:0]  modes[6] = '{8'h83, 8'hC3, 8'h82, 8'hC2, 8'h80, 8'hC0};
	int          error_cnt = 0;
	int          comparisons = 0;

	always #2.5 sys_clk_i = ~sys_clk_i;

	// Timer source: one pulse every eight cycles
	always @(posedge sys_clk_i)
	begin
		tdiv <= tdiv + 3'h1;
		tmr2 <= (tdiv == 3'h7);
	end

	twsio_top i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.timer2_output_i(tmr2), .serial_in_pin_i(si_w), .serial_in_pin_o(si_o),
		.serial_in_pin_oe_o(si_oe), .serial_out_pin_i(so_w), .serial_out_pin_o(so_o),
		.serial_out_pin_oe_o(so_oe), .serial_clock_pin_i(sck_w),
		.serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
		.transfer_done_irq_flag_o(done), .auto_transfer_select_o(ats), .busy_o(busy));

	twsio_peer i_peer (.sck_i(sck_w), .sdi_i(so_w), .sdo_o(p_sdo), .sck_o(p_sck),
		.sck_oe_o(p_sck_oe));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr_reg(input twsio_addr_t a, input twsio_byte_t d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	task automatic rd_reg(input twsio_addr_t a, input twsio_byte_t e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 600 && busy !== 1'b0; i++)
			@(posedge sys_clk_i);
		if (busy !== 1'b0)
		begin
			error_cnt++;
			complete_run();
		end
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk_i)
	begin
		if (rd_q && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
		rd_q <= rd;
	end

	task automatic xfer(input logic [7:0] mode);
		logic [7:0] tx;
		logic [7:0] pb;
		tx = 8'($urandom);
		pb = 8'($urandom);
		wr_reg(ADR_MODE, mode);
		i_peer.load(pb);
		addr <= ADR_SHIFT;
		wdata <= tx;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
		#1;
		check({7'h0, busy}, 8'h01);
		check({7'h0, so_o}, 8'h00);
		check({7'h0, sck_oe}, {7'h0, mode[1]});
		if (!mode[1])
			i_peer.run_clock(50);
		wait_idle();
		@(posedge sys_clk_i);
		#1;
		check({7'h0, done}, 8'h01);
		check({7'h0, sck_w}, 8'h01);
		check(i_peer.rx_q, mode[6] ? rev8(tx) : tx);
		rd_reg(ADR_SHIFT, mode[6] ? rev8(pb) : pb);
		wr_reg(ADR_STAT, 8'h01);
		rd_reg(ADR_STAT, 8'h00);
		$display("transfer mode %h done", mode);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(94227));
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_reg(ADR_MODE, 8'h00);
		rd_reg(ADR_PRESC, 8'h88);
		rd_reg(16'hFF00, 8'h00);
		check({6'h0, sck_oe, so_oe}, 8'h00);
		$display("reset test done");
		wr_reg(ADR_MODE, 8'hFF);
		check({7'h0, ats}, 8'h01);
		rd_reg(ADR_MODE, 8'hE3);
		wr_reg(ADR_MODE, 8'h00);
		check({7'h0, ats}, 8'h00);
		$display("mode test done");
		wr_reg(ADR_SHIFT, 8'h5A);
		wr_reg(ADR_MODE, 8'h83);
		repeat (20) @(posedge sys_clk_i);
		#1;
		check({7'h0, busy}, 8'h00);
		check({6'h0, sck_oe, sck_o}, 8'h03);
		rd_reg(ADR_SHIFT, 8'h5A);
		$display("late enable test done");
		wr_reg(ADR_PDIR, 8'hFE);
		wr_reg(ADR_PLAT, 8'h01);
		wr_reg(ADR_AUTO, 8'h00);
		#1;
		check({6'h0, si_oe, si_o}, 8'h03);
		wr_reg(ADR_AUTO, 8'h80);
		#1;
		check({7'h0, si_oe}, 8'h00);
		wr_reg(ADR_PDIR, 8'hFF);
		$display("port test done");
		wr_reg(ADR_PRESC, 8'h20);
		foreach (modes[k])
			xfer(modes[k]);
		// Disabling mid-frame aborts with no completion
		wr_reg(ADR_MODE, 8'h83);
		wr_reg(ADR_SHIFT, 8'hA5);
		check({7'h0, busy}, 8'h01);
		repeat (30) @(posedge sys_clk_i);
		wr_reg(ADR_MODE, 8'h03);
		#1;
		check({6'h0, busy, done}, 8'h00);
		rd_reg(ADR_STAT, 8'h00);
		$display("abort test done");
		@(posedge sys_clk_i);
		complete_run();
	end
endmodule
